// ==== nvm_program_control.v ====
/*
 programming control for program memory and data memory: the combined
 control register, the separate program memory register, the block
 protect register with its post-reset window, and the voltage enable
 sequence.
 assumes: one clock (E clock), async active-low reset, mode inputs from
 the same clock domain, memory writes reported on mem_wr/mem_addr.
*/
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_program_control_regs.vh"

// Contract
// - program latch set: memory writes latch address and data, reads blocked.
// - program latch always readable; writes ignored while voltage enable set.
// - combined register: one voltage enable; both latches never set together.
// - voltage enable readable; writable only while a latch bit is set.
// - voltage enable 1 connects programming voltage, 0 disconnects it.
// - multi-byte enable makes address bit 5 don't-care when programming.
// - multi-byte enable reads 0 in normal modes, writable only in special.
// - extra columns: user array off, address 13:5 decoded, special modes only.
// - extra rows: user array off, address 7:0 decoded, special modes only.
// - test select 00 normal, 01 reserved, 10 gate, 11 drain stress.
// - separate register voltage enable writable only while its latch is set.
// - erased bits read 1; programming 1 keeps bit, programming 0 clears.
// - control register always accessible; data latch clear means ROM-like reads.
// - charge pump clocked by E clock when select is 0, RC when 1.
// - voltage only after latch write, memory write, then both-bits write; the program latch path needs no memory write first.
// - one write setting data latch and voltage enable leaves both clear.
// - protect bits set at reset; clear only in first 64 cycles, normal modes.
// - test or bootstrap modes: block protect writable repeatedly.
// - protect bits 7:5 read 0; config protect blocks config programming.
// - each of protect bits 3:0 guards its block of the 512-byte array.
// - 2048-byte variant: four 512-byte quarters, top nibble from base select.
// - data latch set: buses set up for programming or erase, reads blocked.
// - erase: byte overrides row; 00 bulk, 01 16-byte row, 1x single byte.
module nvm_program_control #(
   parameter LARGE_ARRAY = 0
) (
   input  wire        clk,
   input  wire        resetn,
   input  wire [1:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   input  wire        special_mode,
   input  wire [3:0]  data_memory_base_select,
   input  wire        mem_wr,
   input  wire [15:0] mem_addr,
   input  wire [7:0]  mem_wdata,
   output wire        program_read_block,
   output wire        data_read_block,
   output wire        program_voltage_on,
   output wire        data_voltage_on,
   output wire        program_array_voltage_on,
   output reg  [15:0] latched_addr,
   output reg  [7:0]  latched_data,
   output reg         latched_valid,
   output wire        latched_addr5_dont_care,
   output wire        user_array_disable,
   output wire [13:0] array_addr_mask,
   output wire [1:0]  test_stress_select,
   output wire [1:0]  erase_kind,
   output wire        erase_mode,
   output wire        charge_pump_clock_select,
   output wire        program_blocked
);
   localparam [1:0] ERASE_BULK = 2'h0;
   localparam [1:0] ERASE_ROW  = 2'h1;
   localparam [1:0] ERASE_BYTE = 2'h2;

   // data memory voltage sequence
   localparam [1:0] SEQ_IDLE    = 2'h0;
   localparam [1:0] SEQ_LATCHED = 2'h1;
   localparam [1:0] SEQ_ARMED   = 2'h2;
   localparam [1:0] SEQ_ON      = 2'h3;

   localparam [7:0] BP_RESET_FULL = `BP_RESET;

   reg  [7:0] npc_r;
   reg  [7:0] pmc_r;
   reg  [4:0] bp_r;
   reg        charge_pump_clock_select_r;
   reg  [6:0] win_cnt_r;
   reg  [1:0] seq_r;
   reg  [1:0] seq_nxt;
   reg  [7:0] npc_nxt;
   reg  [7:0] pmc_nxt;
   wire       win_open;
   wire       dm_in_array;
   wire       dm_protected;
   wire       cfg_hit;
   wire       wr_npc;
   wire       wr_pmc;
   wire       wr_bp;
   wire       seq_ok;
   wire       dm_prot_latched;

   assign wr_npc   = reg_wr && reg_addr == `OFS_NVM_PROGRAM_CONTROL;
   assign wr_pmc   = reg_wr && reg_addr == `OFS_PROGRAM_MEMORY_CTRL;
   assign wr_bp    = reg_wr && reg_addr == `OFS_BLOCK_PROTECT;
   assign win_open = win_cnt_r < `BP_WINDOW_CYCLES;
   assign cfg_hit  = mem_addr == `CONFIG_ADDR;
   assign seq_ok   = seq_r == SEQ_ARMED || seq_r == SEQ_ON;

   block_protect_decode #(
      .LARGE_ARRAY (LARGE_ARRAY)
   ) u_decode (
      .addr               (mem_addr),
      .base_select        (data_memory_base_select),
      .block_protect_bits (bp_r[`BP_BLOCKS_HI:0]),
      .in_array           (dm_in_array),
      .protected_hit      (dm_protected)
   );

   // combined control register next value
   always @* begin
      npc_nxt = npc_r;
      if (wr_npc) begin
         npc_nxt[`NPC_ODD]   = reg_wdata[`NPC_ODD];
         npc_nxt[`NPC_EVEN]  = reg_wdata[`NPC_EVEN];
         npc_nxt[`NPC_BYTE]  = reg_wdata[`NPC_BYTE];
         npc_nxt[`NPC_ROW]   = reg_wdata[`NPC_ROW];
         npc_nxt[`NPC_ERASE] = reg_wdata[`NPC_ERASE];
         if (!npc_r[`NPC_VOLT]) begin
            npc_nxt[`NPC_PLAT] = reg_wdata[`NPC_PLAT];
            npc_nxt[`NPC_DLAT] = reg_wdata[`NPC_DLAT];
         end
         // latches exclusive: a write asking for both leaves both latch bits unchanged
         if (npc_nxt[`NPC_PLAT] && npc_nxt[`NPC_DLAT]) begin
            npc_nxt[`NPC_PLAT] = npc_r[`NPC_PLAT];
            npc_nxt[`NPC_DLAT] = npc_r[`NPC_DLAT];
         end
         if (npc_r[`NPC_PLAT] || npc_r[`NPC_DLAT])
            npc_nxt[`NPC_VOLT] = reg_wdata[`NPC_VOLT];
         // data path voltage needs the armed sequence
         if (reg_wdata[`NPC_VOLT] && npc_r[`NPC_DLAT] && !seq_ok)
            npc_nxt[`NPC_VOLT] = 1'b0;
         if (reg_wdata[`NPC_DLAT] && reg_wdata[`NPC_VOLT] && !npc_r[`NPC_DLAT]) begin
            npc_nxt[`NPC_DLAT] = 1'b0;
            npc_nxt[`NPC_VOLT] = 1'b0;
         end
      end
   end

   // latch write, then a valid data or config write, then voltage
   always @* begin
      seq_nxt = seq_r;
      case (seq_r)
         SEQ_IDLE: begin
            if (wr_npc && npc_nxt[`NPC_DLAT] && !npc_nxt[`NPC_VOLT])
               seq_nxt = SEQ_LATCHED;
         end
         SEQ_LATCHED: begin
            if (mem_wr && !npc_r[`NPC_VOLT] && (dm_in_array || cfg_hit))
               seq_nxt = SEQ_ARMED;
         end
         SEQ_ARMED: begin
            if (wr_npc && npc_nxt[`NPC_VOLT])
               seq_nxt = SEQ_ON;
            else if (wr_npc)
               seq_nxt = SEQ_LATCHED;
         end
         SEQ_ON: begin
            // voltage off needs a fresh memory write before the next enable
            if (wr_npc && !npc_nxt[`NPC_VOLT])
               seq_nxt = SEQ_LATCHED;
         end
         default: begin
            seq_nxt = SEQ_IDLE;
         end
      endcase
      if (!npc_nxt[`NPC_DLAT])
         seq_nxt = SEQ_IDLE;
   end

   // separate program memory register next value
   always @* begin
      pmc_nxt = pmc_r;
      if (wr_pmc) begin
         if (!pmc_r[`PMC_PGM])
            pmc_nxt[`PMC_PLAT] = reg_wdata[`PMC_PLAT];
         if (pmc_r[`PMC_PLAT])
            pmc_nxt[`PMC_PGM] = reg_wdata[`PMC_PGM];
         if (special_mode) begin
            pmc_nxt[`PMC_MBE]     = reg_wdata[`PMC_MBE];
            pmc_nxt[`PMC_EXTRA_COLUMNS_SELECT]   = reg_wdata[`PMC_EXTRA_COLUMNS_SELECT];
            pmc_nxt[`PMC_EXTRA_ROWS_SELECT]   = reg_wdata[`PMC_EXTRA_ROWS_SELECT];
            pmc_nxt[`PMC_TEST_HI] = reg_wdata[`PMC_TEST_HI];
            pmc_nxt[`PMC_TEST_LO] = reg_wdata[`PMC_TEST_LO];
         end
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         npc_r     <= `NPC_RESET;
         pmc_r     <= `PMC_RESET;
         bp_r      <= BP_RESET_FULL[4:0];
         charge_pump_clock_select_r    <= 1'b0;
         win_cnt_r <= 7'h00;
         seq_r     <= SEQ_IDLE;
      end else begin
         npc_r  <= npc_nxt;
         pmc_r  <= pmc_nxt;
         if (reg_wr && reg_addr == `OFS_OPTION_SELECT)
            charge_pump_clock_select_r <= reg_wdata[`OPT_CHARGE_PUMP_CLOCK_SELECT];
         if (win_open)
            win_cnt_r <= win_cnt_r + 7'h01;
         if (wr_bp) begin
            if (special_mode || win_open)
               bp_r <= reg_wdata[4:0];
            else
               bp_r <= bp_r | reg_wdata[4:0];
         end
         seq_r  <= seq_nxt;
      end
   end

   // memory write capture while a latch is set
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         latched_addr  <= 16'h0000;
         latched_data  <= 8'hFF;
         latched_valid <= 1'b0;
      end else begin
         if (mem_wr && (program_read_block || data_read_block) && !program_voltage_on) begin
            latched_addr  <= mem_addr;
            latched_data  <= mem_wdata;
            latched_valid <= 1'b1;
         end else if (!program_read_block && !data_read_block) begin
            latched_valid <= 1'b0;
         end
      end
   end

   // register read port, data one cycle after the strobe
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFS_NVM_PROGRAM_CONTROL: reg_rdata <= npc_r;
            `OFS_PROGRAM_MEMORY_CTRL:
               reg_rdata <= special_mode ? pmc_r
                            : (pmc_r & 8'h21);
            `OFS_BLOCK_PROTECT: reg_rdata <= {3'h0, bp_r};
            `OFS_OPTION_SELECT: reg_rdata <= {7'h00, charge_pump_clock_select_r};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   assign program_read_block = LARGE_ARRAY != 0 ? pmc_r[`PMC_PLAT]
                               : npc_r[`NPC_PLAT];
   assign data_read_block    = npc_r[`NPC_DLAT];
   assign program_voltage_on = npc_r[`NPC_VOLT];
   assign data_voltage_on    = npc_r[`NPC_VOLT] & npc_r[`NPC_DLAT];
   assign program_array_voltage_on = pmc_r[`PMC_PGM];
   assign latched_addr5_dont_care  = pmc_r[`PMC_MBE] & special_mode;
   assign user_array_disable = special_mode & (pmc_r[`PMC_EXTRA_COLUMNS_SELECT] | pmc_r[`PMC_EXTRA_ROWS_SELECT]);
   assign array_addr_mask = !special_mode ? 14'h3FFF
                            : pmc_r[`PMC_EXTRA_COLUMNS_SELECT] ? 14'h3FE0
                            : pmc_r[`PMC_EXTRA_ROWS_SELECT] ? 14'h00FF
                            : latched_addr5_dont_care ? 14'h3FDF : 14'h3FFF;
   assign test_stress_select = special_mode ?
                               {pmc_r[`PMC_TEST_HI], pmc_r[`PMC_TEST_LO]} : 2'h0;
   assign erase_mode = npc_r[`NPC_ERASE] & npc_r[`NPC_DLAT];
   assign erase_kind = npc_r[`NPC_BYTE] ? ERASE_BYTE
                       : npc_r[`NPC_ROW] ? ERASE_ROW : ERASE_BULK;
   assign charge_pump_clock_select = charge_pump_clock_select_r;
   assign program_blocked = latched_valid && npc_r[`NPC_DLAT] &&
                            (latched_addr == `CONFIG_ADDR ? bp_r[`BP_CFG]
                             : dm_prot_latched);

   block_protect_decode #(
      .LARGE_ARRAY (LARGE_ARRAY)
   ) u_decode_latched (
      .addr               (latched_addr),
      .base_select        (data_memory_base_select),
      .block_protect_bits (bp_r[`BP_BLOCKS_HI:0]),
      .in_array           (),
      .protected_hit      (dm_prot_latched)
   );
endmodule // nvm_program_control

`default_nettype wire

// ==== nvm_program_control_regs.vh ====
/*
 register offsets, field positions, reset values and timing counts for the
 nonvolatile memory programming control block.
 assumes: included by the block's design files only.
*/
`ifndef NVM_PROGRAM_CONTROL_REGS_VH
`define NVM_PROGRAM_CONTROL_REGS_VH

// register offsets on the plain register port
`define OFS_NVM_PROGRAM_CONTROL   2'h0
`define OFS_PROGRAM_MEMORY_CTRL   2'h1
`define OFS_BLOCK_PROTECT         2'h2
`define OFS_OPTION_SELECT         2'h3

// nvm_program_control fields
`define NPC_VOLT      0
`define NPC_DLAT      1
`define NPC_ERASE     2
`define NPC_ROW       3
`define NPC_BYTE      4
`define NPC_PLAT      5
`define NPC_EVEN      6
`define NPC_ODD       7

// program_memory_program_control fields
`define PMC_PGM       0
`define PMC_TEST_LO   1
`define PMC_TEST_HI   2
`define PMC_EXTRA_ROWS_SELECT     3
`define PMC_EXTRA_COLUMNS_SELECT     4
`define PMC_PLAT      5
`define PMC_MBE       7

// data_memory_block_protect fields
`define BP_BLOCKS_HI  3
`define BP_CFG        4
`define BP_MASK       8'h1F

// option select register field
`define OPT_CHARGE_PUMP_CLOCK_SELECT      0

// reset values
`define NPC_RESET     8'h00
`define PMC_RESET     8'h00
`define BP_RESET      8'h1F

// block protect write window after reset, in E-clock cycles
`define BP_WINDOW_CYCLES 7'd64

// data memory block bounds, 512-byte layout
`define DM_BASE_512   16'hB600
`define DM_B1_512     16'hB620
`define DM_B2_512     16'hB660
`define DM_B3_512     16'hB6E0
`define DM_END_512    16'hB7FF

// config register address and 2048-byte layout block offset
`define CONFIG_ADDR   16'h103F
`define DM_OFS_2K     4'h8

`endif

// ==== block_protect_decode.v ====
/*
 maps a data memory address to its protecting block and reports whether
 that block is write protected.
 assumes: combinational use by the control block on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "nvm_program_control_regs.vh"

module block_protect_decode #(
   parameter LARGE_ARRAY = 0
) (
   input  wire [15:0] addr,
   input  wire [3:0]  base_select,
   input  wire [3:0]  block_protect_bits,
   output reg         in_array,
   output reg         protected_hit
);
   reg [1:0] blk;

   always @* begin
      blk      = 2'h0;
      in_array = 1'b0;
      if (LARGE_ARRAY != 0) begin
         // four 512-byte quarters, top nibble from base select
         if (addr[15:12] == base_select && addr[11]) begin
            in_array = 1'b1;
            blk      = addr[10:9];
         end
      end else begin
         if (addr >= `DM_BASE_512 && addr <= `DM_END_512) begin
            in_array = 1'b1;
            if (addr < `DM_B1_512)
               blk = 2'h0;
            else if (addr < `DM_B2_512)
               blk = 2'h1;
            else if (addr < `DM_B3_512)
               blk = 2'h2;
            else
               blk = 2'h3;
         end
      end
      protected_hit = in_array & block_protect_bits[blk];
   end
endmodule // block_protect_decode

`default_nettype wire

// ==== nvm_program_control_checker.sv ====
/*
 port assertions for the nonvolatile programming control block.
 assumes: bound to nvm_program_control, one clock, async low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module nvm_program_control_checker (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [1:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        special_mode,
   input wire logic        mem_wr,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0]  mem_wdata,
   input wire logic        program_read_block,
   input wire logic        data_read_block,
   input wire logic        program_voltage_on,
   input wire logic        data_voltage_on,
   input wire logic [15:0] latched_addr,
   input wire logic [7:0]  latched_data,
   input wire logic        latched_valid,
   input wire logic        latched_addr5_dont_care,
   input wire logic        user_array_disable,
   input wire logic [1:0]  test_stress_select,
   input wire logic        charge_pump_clock_select
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   wire cwr = reg_wr && reg_addr == 2'h0;
   a_latch_exclusive: assert property (
      !(program_read_block && data_read_block)) else $error("both latches set");
   a_volt_needs_latch: assert property (
      $rose(program_voltage_on) |-> $past(program_read_block || data_read_block))
      else $error("voltage on without latch");
   a_volt_order: assert property (
      $rose(data_voltage_on) |-> $past(data_read_block)) else $error("data voltage early");
   a_latch_frozen: assert property (
      cwr && program_voltage_on |=> $stable(program_read_block) && $stable(data_read_block))
      else $error("latch changed under voltage");
   a_double_set: assert property (
      cwr && reg_wdata[1:0] == 2'b11 && !data_read_block && !program_read_block
      && !program_voltage_on |=> !data_read_block && !program_voltage_on)
      else $error("latch and voltage set together");
   a_dvolt_pair: assert property (
      data_voltage_on == (program_voltage_on && data_read_block)) else $error("data voltage");
   a_capture_mem: assert property (
      mem_wr && (program_read_block || data_read_block) && !program_voltage_on
      |=> latched_valid && latched_addr == $past(mem_addr) && latched_data == $past(mem_wdata))
      else $error("capture lost");
   a_pump_clock: assert property (
      reg_wr && reg_addr == 2'h3 |=> charge_pump_clock_select == $past(reg_wdata[0]))
      else $error("pump clock select");
   a_normal_gate: assert property (
      !special_mode |-> !latched_addr5_dont_care && !user_array_disable
      && test_stress_select == 2'b00) else $error("special bits in normal mode");
   a_protect_top: assert property (
      reg_rd && reg_addr == 2'h2 |=> reg_rdata[7:5] == 3'b000) else $error("protect top bits");
endmodule // nvm_program_control_checker
bind nvm_program_control nvm_program_control_checker nvm_program_control_checker_inst (
   .clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .special_mode,
   .mem_wr, .mem_addr, .mem_wdata, .program_read_block, .data_read_block,
   .program_voltage_on, .data_voltage_on, .latched_addr, .latched_data, .latched_valid,
   .latched_addr5_dont_care, .user_array_disable, .test_stress_select,
   .charge_pump_clock_select);
`default_nettype wire

// ==== nvm_program_control_bench.sv ====
/*
 self-checking bench for the nonvolatile programming control block.
 assumes: default small-array layout, 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nvm_program_control_bench;
   logic        clk, resetn, reg_wr, reg_rd, special_mode, mem_wr;
   logic [1:0]  reg_addr, ek, tss;
   logic [7:0]  reg_wdata, mem_wdata, reg_rdata, latched_data;
   logic [15:0] mem_addr, latched_addr, a;
   logic        prb, drb, pvo, dvo, lv, em, cps, a5, uad, pav, pbl;
   logic [13:0] mask;
   logic [31:0] seed, r;
   logic [7:0]  kinds [4] = '{8'h06, 8'h0E, 8'h16, 8'h1E};
   int          failures, n_checks, cycles;
   nvm_program_control nvm_program_control_inst (
      .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode),
      .data_memory_base_select(4'hB), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .program_read_block(prb), .data_read_block(drb),
      .program_voltage_on(pvo), .data_voltage_on(dvo), .program_array_voltage_on(pav),
      .latched_addr(latched_addr), .latched_data(latched_data), .latched_valid(lv),
      .latched_addr5_dont_care(a5), .user_array_disable(uad), .array_addr_mask(mask),
      .test_stress_select(tss), .erase_kind(ek), .erase_mode(em),
      .charge_pump_clock_select(cps), .program_blocked(pbl));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [1:0] kind_of(input logic [7:0] v);
      return v[4] ? 2'h2 : {1'b0, v[3]};
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [1:0] ad, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [1:0] ad, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", reg_rdata, e);
   endtask
   task automatic mwr(input logic [15:0] ad);
      a = ad;
      r = rnd();
      @(posedge clk);
      mem_addr <= a;
      mem_wdata <= r[23:16];
      mem_wr <= 1'b1;
      @(posedge clk);
      mem_wr <= 1'b0;
      #1;
      chk("latched_addr", latched_addr, a);
      chk("latched_data", latched_data, r[23:16]);
      chk("latched_valid", lv, 1'b1);
   endtask
   task automatic complete_run();
      if (failures == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         complete_run();
      end
   end
   initial begin
      {resetn, reg_wr, reg_rd, special_mode, mem_wr, reg_addr} = '0;
      {reg_wdata, mem_wdata, mem_addr} = '0;
      seed = 32'h45B1;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rd(2'h2, 8'h1F);
      rd(2'h0, 8'h00);
      wr(2'h2, 8'h00);
      rd(2'h2, 8'h00);
      repeat (64) @(posedge clk);
      wr(2'h2, 8'hFF);
      rd(2'h2, 8'h1F);
      wr(2'h2, 8'h00);
      rd(2'h2, 8'h1F);
      wr(2'h0, 8'h03);
      rd(2'h0, 8'h00);
      wr(2'h0, 8'h01);
      rd(2'h0, 8'h00);
      wr(2'h0, 8'h02);
      mwr(16'h1000);
      wr(2'h0, 8'h03);
      rd(2'h0, 8'h02);
      wr(2'h0, 8'h02);
      chk("data_read_block", drb, 1'b1);
      r = rnd();
      mwr(16'hB600 + {7'h00, r[8:0]});
      chk("program_blocked", pbl, 1'b1);
      wr(2'h0, 8'h03);
      chk("data_voltage_on", dvo, 1'b1);
      wr(2'h0, 8'h00);
      rd(2'h0, 8'h02);
      chk("program_voltage_on", pvo, 1'b0);
      wr(2'h0, 8'h00);
      rd(2'h0, 8'h00);
      chk("latched_valid", lv, 1'b0);
      wr(2'h0, 8'h20);
      chk("program_read_block", prb, 1'b1);
      wr(2'h0, 8'h22);
      rd(2'h0, 8'h20);
      r = rnd();
      mwr(16'hB600 + {7'h00, r[8:0]});
      wr(2'h0, 8'h21);
      chk("program_voltage_on", pvo, 1'b1);
      wr(2'h0, 8'h00);
      wr(2'h0, 8'h00);
      foreach (kinds[i]) begin
         wr(2'h0, kinds[i]);
         chk("erase_mode", em, 1'b1);
         chk("erase_kind", ek, kind_of(kinds[i]));
      end
      wr(2'h0, 8'h00);
      repeat (4) begin
         r = rnd();
         wr(2'h3, {7'h00, r[0]});
         chk("charge_pump_clock_select", cps, r[0]);
      end
      @(posedge clk);
      special_mode <= 1'b1;
      wr(2'h2, 8'h00);
      rd(2'h2, 8'h00);
      wr(2'h2, 8'h05);
      wr(2'h2, 8'h0A);
      rd(2'h2, 8'h0A);
      wr(2'h1, 8'h88);
      chk("array_addr_mask", mask, 14'h00FF);
      chk("user_array_disable", uad, 1'b1);
      wr(2'h1, 8'h96);
      rd(2'h1, 8'h96);
      chk("array_addr_mask", mask, 14'h3FE0);
      chk("test_stress_select", tss, 2'h3);
      wr(2'h1, 8'h80);
      chk("array_addr_mask", mask, 14'h3FDF);
      chk("latched_addr5_dont_care", a5, 1'b1);
      wr(2'h1, 8'h01);
      chk("program_array_voltage_on", pav, 1'b0);
      wr(2'h1, 8'h20);
      wr(2'h1, 8'h21);
      chk("program_array_voltage_on", pav, 1'b1);
      wr(2'h1, 8'h00);
      rd(2'h1, 8'h20);
      chk("program_array_voltage_on", pav, 1'b0);
      wr(2'h0, 8'h02);
      mwr(16'hB600);
      chk("program_blocked", pbl, 1'b0);
      mwr(16'hB620);
      chk("program_blocked", pbl, 1'b1);
      wr(2'h2, 8'h1A);
      mwr(16'h103F);
      chk("program_blocked", pbl, 1'b1);
      wr(2'h1, 8'h96);
      @(posedge clk);
      special_mode <= 1'b0;
      rd(2'h1, 8'h00);
      chk("latched_addr5_dont_care", a5, 1'b0);
      chk("array_addr_mask", mask, 14'h3FFF);
      chk("test_stress_select", tss, 2'h0);
      chk("user_array_disable", uad, 1'b0);
      complete_run();
   end
endmodule // nvm_program_control_bench
`default_nettype wire
